/* hdl/adc_cfg.svh */
/*
  Constants of the converter sequencing block: register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Operation
// - With stop-after-first-irq set, the first converter interrupt halts conversions and clears sample_autostart.
// - With stop-after-first-irq clear, conversion runs on and each new result overwrites the result buffer.
// - With sample_autostart set, sampling restarts right after a conversion completes and sample_enable sets itself.
// - With sample_autostart clear, sampling starts only when software writes one to sample_enable.
// - sample_enable reads one while the sample-and-hold acquires and zero while it holds.
// - With trigger source zero, a software write of zero to sample_enable ends sampling and starts conversion.
// - With a nonzero trigger source, hardware clears sample_enable itself to end sampling and start conversion.
// - Hardware sets the done flag when a conversion completes; it reads zero otherwise.
// - Software clears the done flag by writing zero, never writes one, and clearing does not disturb a conversion.
// - Hardware clears the done flag when a new conversion begins.
// - The unused bit between the stop bit and the autostart bit always reads zero.
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

`define ADC_ADDR_W        12
`define ADC_OFF_CTRL      12'h000
`define ADC_OFF_STAT      12'h004
`define ADC_OFF_MASK      12'h008
`define ADC_OFF_RESULT    12'h00C
`define ADC_OFF_TIMING    12'h010

`define CTRL_ON_BIT       15
`define CTRL_SRC_HI       7
`define CTRL_SRC_LO       5
`define CTRL_STOP_BIT     4
`define CTRL_AUTO_BIT     2
`define CTRL_SAMPLE_ENABLE_BIT     1
`define CTRL_DONE_BIT     0

`define SRC_MANUAL        3'h0
`define SRC_AUTO_TIMER    3'h7

`define STAT_CONV_BIT     0
`define STAT_HALT_BIT     1
`define STAT_W            2

`define RES_W             10
`define SAMPLE_ENABLE_W            5
`define SAMPLE_ENABLE_TIME_RST     5'h01
`define SAMPLE_ENABLE_CNT_ONE      5'h01

`define PCLK_DIV_LAST     2'h1
`define CONV_TICKS_LAST   4'hB
`define CONV_CNT_ONE      4'h1
`define DIV_CNT_ONE       2'h1

`endif

/* hdl/adc_pkg.sv */
/*
  Types shared by the converter sequencing block.
  Assumes adc_cfg.svh is on the include path.
*/
`include "adc_cfg.svh"

package adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } phase_t;

  typedef struct packed {
    logic       on;
    logic [2:0] conversion_trigger_source;
    logic       stop_after_first_irq;
    logic       sample_autostart;
  } ctrl_t;

  typedef struct packed {
    logic                conv_done;
    logic [`RES_W-1:0]   data;
  } conv_out_t;

endpackage : adc_pkg

/* hdl/adc_conv_timer.sv */
/*
  Peripheral clock divider and conversion duration counter.
  Assumes start is a one-cycle pulse on clk and abort is a level.
*/
`timescale 1ns/1ps
`include "adc_cfg.svh"

module adc_conv_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  input  wire logic abort,
  // Status
  output logic      tick,
  output logic      busy,
  output logic      finish
);

  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       busy_next;
  logic       finish_next;

  // Divider runs free so sample timing is never phase locked to software
  always_comb begin
    div_next = (div_reg == `PCLK_DIV_LAST) ? 2'h0 : div_reg + `DIV_CNT_ONE;
    tick     = (div_reg == `PCLK_DIV_LAST);
    cnt_next    = cnt_reg;
    busy_next   = busy;
    finish_next = 1'b0;
    if (abort) begin
      busy_next = 1'b0;
      cnt_next  = 4'h0;
    end else if (start) begin
      busy_next = 1'b1;
      cnt_next  = 4'h0;
    end else if (busy && tick) begin
      if (cnt_reg == `CONV_TICKS_LAST) begin
        busy_next   = 1'b0;
        finish_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + `CONV_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 2'h0;
      cnt_reg <= 4'h0;
      busy    <= 1'b0;
      finish  <= 1'b0;
    end else begin
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      busy    <= busy_next;
      finish  <= finish_next;
    end
  end

endmodule : adc_conv_timer

/* hdl/adc_sample_convert_control.sv */
/*
  Sample and conversion sequencer with APB register slave and interrupt.
  Assumes an APB master on clk, an analog core that presents its result on
  conv_data while a conversion runs, and an optional external trigger pin.
*/
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "adc_cfg.svh"

module adc_sample_convert_control (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`ADC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Analog core
  input  wire logic                   ext_trigger,
  input  wire logic [`RES_W-1:0]      conv_data,
  output logic                        sample_hold,
  output logic                        conv_start,
  // Interrupt
  output logic                        irq
);

  function automatic logic hit(input logic [`ADC_ADDR_W-1:0] a, input logic [`ADC_ADDR_W-1:0] off);
    return a[`ADC_ADDR_W-1:2] == off[`ADC_ADDR_W-1:2];
  endfunction : hit

  // APB decode
  logic setup;
  logic access;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic wr_timing;
  logic mapped;

  assign setup     = psel & ~penable;
  assign access    = psel & penable & pready;
  assign wr_ctrl   = access & pwrite & hit(paddr, `ADC_OFF_CTRL);
  assign wr_stat   = access & pwrite & hit(paddr, `ADC_OFF_STAT);
  assign wr_mask   = access & pwrite & hit(paddr, `ADC_OFF_MASK);
  assign wr_timing = access & pwrite & hit(paddr, `ADC_OFF_TIMING);
  assign mapped    = hit(paddr, `ADC_OFF_CTRL) | hit(paddr, `ADC_OFF_STAT) | hit(paddr, `ADC_OFF_MASK)
                   | hit(paddr, `ADC_OFF_RESULT) | hit(paddr, `ADC_OFF_TIMING);

  // Pin synchronisers
  logic              trig_meta_reg;
  logic              trig_sync_reg;
  logic              trig_prev_reg;
  logic [`RES_W-1:0] data_meta_reg;
  logic [`RES_W-1:0] data_sync_reg;
  logic              trig_rise;

  assign trig_rise = trig_sync_reg & ~trig_prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      data_meta_reg <= '0;
      data_sync_reg <= '0;
    end else begin
      trig_meta_reg <= ext_trigger;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
      data_meta_reg <= conv_data;
      data_sync_reg <= data_meta_reg;
    end
  end

  // Conversion timing
  logic tick;
  logic conv_busy;
  logic conv_finish;
  logic start_conv;
  adc_pkg::ctrl_t ctrl_reg;

  adc_conv_timer u_timer (
    .clk    (clk),
    .rst    (rst),
    .start  (start_conv),
    .abort  (~ctrl_reg.on),
    .tick   (tick),
    .busy   (conv_busy),
    .finish (conv_finish)
  );

  // Sequencer state
  adc_pkg::phase_t        state_reg;
  adc_pkg::phase_t        state_next;
  adc_pkg::ctrl_t         ctrl_next;
  logic                   done_reg;
  logic                   done_next;
  logic [`SAMPLE_ENABLE_W-1:0]     sample_enable_time_reg;
  logic [`SAMPLE_ENABLE_W-1:0]     sample_enable_time_next;
  logic [`SAMPLE_ENABLE_W-1:0]     sample_enable_cnt_reg;
  logic [`SAMPLE_ENABLE_W-1:0]     sample_enable_cnt_next;
  logic [`SAMPLE_ENABLE_W-1:0]     sample_enable_goal;
  logic [`RES_W-1:0]      result_reg;
  logic [`RES_W-1:0]      result_next;
  logic                   halt_evt;
  logic                   finish_ok;
  logic                   sample_enable_end;

  assign finish_ok = conv_finish & (state_reg == adc_pkg::ST_CONVERT);
  // A zero sample time would end sampling before any acquisition, so it acts as one tick
  assign sample_enable_goal = (sample_enable_time_reg == '0) ? `SAMPLE_ENABLE_CNT_ONE : sample_enable_time_reg;
  assign sample_enable_end  = tick & ((sample_enable_cnt_reg + `SAMPLE_ENABLE_CNT_ONE) >= sample_enable_goal);

  always_comb begin
    ctrl_next      = ctrl_reg;
    sample_enable_time_next = sample_enable_time_reg;
    state_next     = state_reg;
    halt_evt       = 1'b0;
    result_next    = result_reg;
    if (wr_ctrl) begin
      ctrl_next.on                        = pwdata[`CTRL_ON_BIT];
      ctrl_next.conversion_trigger_source = pwdata[`CTRL_SRC_HI:`CTRL_SRC_LO];
      ctrl_next.stop_after_first_irq      = pwdata[`CTRL_STOP_BIT];
      ctrl_next.sample_autostart          = pwdata[`CTRL_AUTO_BIT];
    end
    if (wr_timing) begin
      sample_enable_time_next = pwdata[`SAMPLE_ENABLE_W-1:0];
    end
    case (state_reg)
      adc_pkg::ST_IDLE: begin
        if (ctrl_next.sample_autostart) begin
          state_next = adc_pkg::ST_SAMPLE;
        end else if (wr_ctrl && pwdata[`CTRL_SAMPLE_ENABLE_BIT]) begin
          state_next = adc_pkg::ST_SAMPLE;
        end
      end
      adc_pkg::ST_SAMPLE: begin
        if (ctrl_reg.conversion_trigger_source == `SRC_MANUAL) begin
          if (wr_ctrl && !pwdata[`CTRL_SAMPLE_ENABLE_BIT]) begin
            state_next = adc_pkg::ST_CONVERT;
          end
        end else if (ctrl_reg.conversion_trigger_source == `SRC_AUTO_TIMER) begin
          if (sample_enable_end) begin
            state_next = adc_pkg::ST_CONVERT;
          end
        end else if (trig_rise) begin
          state_next = adc_pkg::ST_CONVERT;
        end
      end
      adc_pkg::ST_CONVERT: begin
        if (finish_ok) begin
          result_next = data_sync_reg;
          if (ctrl_reg.stop_after_first_irq) begin
            // Hardware clear beats a software write of the same cycle
            ctrl_next.sample_autostart = 1'b0;
            halt_evt                   = 1'b1;
            state_next                 = adc_pkg::ST_IDLE;
          end else if (ctrl_next.sample_autostart) begin
            state_next = adc_pkg::ST_SAMPLE;
          end else begin
            state_next = adc_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_next = adc_pkg::ST_IDLE;
      end
    endcase
    if (!ctrl_next.on) begin
      state_next = adc_pkg::ST_IDLE;
    end
  end

  assign start_conv = (state_reg != adc_pkg::ST_CONVERT) && (state_next == adc_pkg::ST_CONVERT);

  always_comb begin
    sample_enable_cnt_next = sample_enable_cnt_reg;
    if (state_reg != adc_pkg::ST_SAMPLE) begin
      sample_enable_cnt_next = '0;
    end else if (tick && !sample_enable_end) begin
      sample_enable_cnt_next = sample_enable_cnt_reg + `SAMPLE_ENABLE_CNT_ONE;
    end
  end

  // Completion set wins over every clear of the same cycle
  always_comb begin
    done_next = done_reg;
    if (wr_ctrl && !pwdata[`CTRL_DONE_BIT]) begin
      done_next = 1'b0;
    end
    if (start_conv) begin
      done_next = 1'b0;
    end
    if (finish_ok) begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= adc_pkg::ST_IDLE;
      ctrl_reg      <= '0;
      done_reg      <= 1'b0;
      sample_enable_time_reg <= `SAMPLE_ENABLE_TIME_RST;
      sample_enable_cnt_reg  <= '0;
      result_reg    <= '0;
      sample_hold   <= 1'b0;
      conv_start    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      ctrl_reg      <= ctrl_next;
      done_reg      <= done_next;
      sample_enable_time_reg <= sample_enable_time_next;
      sample_enable_cnt_reg  <= sample_enable_cnt_next;
      result_reg    <= result_next;
      sample_hold   <= (state_next == adc_pkg::ST_SAMPLE);
      conv_start    <= start_conv;
    end
  end

  // Interrupt status and mask
  logic [`STAT_W-1:0] stat_reg;
  logic [`STAT_W-1:0] stat_next;
  logic [`STAT_W-1:0] mask_reg;
  logic [`STAT_W-1:0] mask_next;
  logic [`STAT_W-1:0] stat_set;
  logic               irq_next;

  always_comb begin
    stat_set                 = '0;
    stat_set[`STAT_CONV_BIT] = finish_ok;
    stat_set[`STAT_HALT_BIT] = halt_evt;
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~pwdata[`STAT_W-1:0];
    end
    stat_next = stat_next | stat_set;
    mask_next = wr_mask ? pwdata[`STAT_W-1:0] : mask_reg;
    irq_next  = |(stat_reg & mask_reg);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq      <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq      <= irq_next;
    end
  end

  // APB answer: data captured in the setup cycle, one access cycle, no wait states
  logic [31:0] rdata;
  logic [31:0] prdata_next;
  logic        pready_next;
  logic        pslverr_next;

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit(paddr, `ADC_OFF_CTRL)) begin
      rdata[`CTRL_ON_BIT]               = ctrl_reg.on;
      rdata[`CTRL_SRC_HI:`CTRL_SRC_LO]  = ctrl_reg.conversion_trigger_source;
      rdata[`CTRL_STOP_BIT]             = ctrl_reg.stop_after_first_irq;
      rdata[`CTRL_AUTO_BIT]             = ctrl_reg.sample_autostart;
      rdata[`CTRL_SAMPLE_ENABLE_BIT]             = (state_reg == adc_pkg::ST_SAMPLE);
      rdata[`CTRL_DONE_BIT]             = done_reg;
    end else if (hit(paddr, `ADC_OFF_STAT)) begin
      rdata[`STAT_W-1:0] = stat_reg;
    end else if (hit(paddr, `ADC_OFF_MASK)) begin
      rdata[`STAT_W-1:0] = mask_reg;
    end else if (hit(paddr, `ADC_OFF_RESULT)) begin
      rdata[`RES_W-1:0] = result_reg;
    end else if (hit(paddr, `ADC_OFF_TIMING)) begin
      rdata[`SAMPLE_ENABLE_W-1:0] = sample_enable_time_reg;
    end
    prdata_next  = (setup && !pwrite) ? rdata : prdata;
    pready_next  = setup;
    pslverr_next = setup ? !mapped : pslverr;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_next;
      pready  <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_halt_clears_auto: assert property (
    finish_ok && ctrl_reg.stop_after_first_irq |=> !ctrl_reg.sample_autostart && state_reg == adc_pkg::ST_IDLE)
    else $error("stop after first irq did not halt");
  chk_result_overwrite: assert property (
    finish_ok |=> result_reg == $past(data_sync_reg))
    else $error("result not overwritten on completion");
  chk_auto_resample: assert property (
    finish_ok && ctrl_next.on && ctrl_next.sample_autostart && !ctrl_reg.stop_after_first_irq
    |=> state_reg == adc_pkg::ST_SAMPLE && sample_hold)
    else $error("autostart did not resume sampling");
  chk_manual_start: assert property (
    state_reg == adc_pkg::ST_IDLE && wr_ctrl && pwdata[`CTRL_ON_BIT] && pwdata[`CTRL_SAMPLE_ENABLE_BIT]
    |=> state_reg == adc_pkg::ST_SAMPLE)
    else $error("software start of sampling lost");
  chk_sample_pin_phase: assert property (
    sample_hold == (state_reg == adc_pkg::ST_SAMPLE))
    else $error("sample pin disagrees with phase");
  chk_sw_end_sample: assert property (
    state_reg == adc_pkg::ST_SAMPLE && ctrl_reg.conversion_trigger_source == `SRC_MANUAL && wr_ctrl
    && pwdata[`CTRL_ON_BIT] && !pwdata[`CTRL_SAMPLE_ENABLE_BIT] |=> conv_start ##1 !conv_start)
    else $error("software end of sampling did not convert");
  chk_hw_end_sample: assert property (
    state_reg == adc_pkg::ST_SAMPLE && ctrl_reg.conversion_trigger_source == `SRC_AUTO_TIMER && sample_enable_end
    && ctrl_next.on |=> state_reg == adc_pkg::ST_CONVERT && !sample_hold)
    else $error("hardware end of sampling did not convert");
  chk_done_sets: assert property (
    finish_ok |=> done_reg)
    else $error("done flag not set on completion");
  chk_clear_keeps_conv: assert property (
    state_reg == adc_pkg::ST_CONVERT && conv_busy && wr_ctrl && pwdata[`CTRL_ON_BIT]
    |=> conv_busy || conv_finish)
    else $error("done clear disturbed conversion");
  chk_done_clear_start: assert property (
    start_conv |=> !done_reg && conv_busy)
    else $error("done flag not cleared at conversion start");
  chk_unused_bit_zero: assert property (
    setup && !pwrite && hit(paddr, `ADC_OFF_CTRL) |=> !prdata[`CTRL_STOP_BIT-1])
    else $error("unused control bit read nonzero");
  chk_irq_on_complete: assert property (
    finish_ok && mask_reg[`STAT_CONV_BIT] && !wr_mask |=> ##1 irq)
    else $error("completion interrupt not raised");

endmodule : adc_sample_convert_control

/* sim/tb.sv */
/*
  Self-checking bench for the converter sequencer: register map over APB,
  manual, triggered and auto-start conversion, the stop bit and the interrupt.
  Assumes adc_cfg.svh on the include path; the analog core is played by the bench.
*/
`timescale 1ns/1ps
`include "adc_cfg.svh"

module tb;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
  } row_t;

  logic                   clk;
  logic                   rst;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`ADC_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   ext_trigger;
  logic [`RES_W-1:0]      conv_data;
  logic                   sample_hold;
  logic                   conv_start;
  logic                   irq;
  logic [31:0]            rd_val;
  logic                   err_val;
  int                     mismatches;
  int                     checks;
  row_t                   rows [13];

  adc_sample_convert_control DUT (
    .clk        (clk),
    .rst        (rst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .ext_trigger(ext_trigger),
    .conv_data  (conv_data),
    .sample_hold(sample_hold),
    .conv_start (conv_start),
    .irq        (irq)
  );

  always #5 clk = ~clk;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // Request is held until pready is sampled high; data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) mismatches++;
    rd_val  = prdata;
    err_val = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rd_val, exp);
  endtask : rd_chk

  // Sel 0 waits for the conversion start pulse, otherwise for the interrupt
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel == 0 ? conv_start : irq) !== 1'b1 && n < 200);
    chk_bit(sel == 0 ? conv_start : irq, 1'b1);
  endtask : wait_hi

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    // Watchdog: the whole sequence needs well under a few thousand cycles
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext_trigger = 1'b0;
    conv_data = 10'h2A5;
    rows = '{
      '{1'b0, `ADC_OFF_CTRL,   32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, `ADC_OFF_STAT,   32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, `ADC_OFF_MASK,   32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, `ADC_OFF_RESULT, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, `ADC_OFF_TIMING, 32'h0000_0000, 32'h0000_0001, 1'b0},
      '{1'b1, `ADC_OFF_MASK,   32'h0000_0003, 32'h0000_0000, 1'b0},
      '{1'b0, `ADC_OFF_MASK,   32'h0000_0000, 32'h0000_0003, 1'b0},
      '{1'b1, `ADC_OFF_TIMING, 32'h0000_0008, 32'h0000_0000, 1'b0},
      '{1'b0, `ADC_OFF_TIMING, 32'h0000_0000, 32'h0000_0008, 1'b0},
      '{1'b0, 12'h014,         32'h0000_0000, 32'h0000_0000, 1'b1},
      '{1'b1, `ADC_OFF_RESULT, 32'h0000_03FF, 32'h0000_0000, 1'b0},
      '{1'b1, `ADC_OFF_CTRL,   32'h0000_8008, 32'h0000_0000, 1'b0},
      '{1'b0, `ADC_OFF_CTRL,   32'h0000_0000, 32'h0000_8000, 1'b0}
    };
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      chk_bit(err_val, rows[i].err);
      if (!rows[i].wr) chk_word(rd_val, rows[i].exp);
    end
    chk_word(rd_val, 32'h0000_8000);
    // Manual sequence: software opens and closes the sampling window
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_8002);
    @(posedge clk);
    chk_bit(sample_hold, 1'b1);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_8002);
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_8000);
    wait_hi(0);
    chk_bit(sample_hold, 1'b0);
    wait_hi(1);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_8001);
    rd_chk(`ADC_OFF_RESULT, 32'h0000_02A5);
    rd_chk(`ADC_OFF_STAT, 32'h0000_0001);
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_8001);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_8001);
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_8000);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_8000);
    apb(1'b1, `ADC_OFF_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0);
    // External trigger: software cannot end sampling, the pin does
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_8022);
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_8020);
    repeat (4) @(posedge clk);
    chk_bit(sample_hold, 1'b1);
    ext_trigger <= 1'b1;
    // Two cycles on the pin; a wait of four or more cycles here would let the start pulse pass unseen
    repeat (2) @(posedge clk);
    ext_trigger <= 1'b0;
    wait_hi(0);
    chk_bit(sample_hold, 1'b0);
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_8020);
    wait_hi(1);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_8021);
    apb(1'b1, `ADC_OFF_STAT, 32'h0000_0001);
    // Auto-start on the internal timer; each result replaces the last
    conv_data <= 10'h155;
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_80E4);
    wait_hi(1);
    chk_bit(sample_hold, 1'b1);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_80E7);
    rd_chk(`ADC_OFF_RESULT, 32'h0000_0155);
    conv_data <= 10'h0AA;
    apb(1'b1, `ADC_OFF_STAT, 32'h0000_0001);
    wait_hi(0);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_80E4);
    wait_hi(1);
    rd_chk(`ADC_OFF_RESULT, 32'h0000_00AA);
    // Stop after the first interrupt: auto-start drops and the block idles
    apb(1'b1, `ADC_OFF_STAT, 32'h0000_0001);
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_80F4);
    wait_hi(1);
    rd_chk(`ADC_OFF_STAT, 32'h0000_0003);
    repeat (60) @(posedge clk);
    chk_bit(sample_hold, 1'b0);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_80F1);
    // Switch the block off, then leave the bus quiet for two cycles before the next access
    apb(1'b1, `ADC_OFF_CTRL, 32'h0000_0000);
    @(posedge clk);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_0000);
    // Second reset in mid-run returns every register to its reset value
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_bit(irq, 1'b0);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_0000);
    rd_chk(`ADC_OFF_TIMING, 32'h0000_0001);
    end_of_test();
  end
endmodule : tb
